// File: tsr_defs.svh
// Register offsets, field positions and reset values of the status readout block
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define TSR_IDX_NOISE_MARGIN   4'h2
`define TSR_IDX_COEF_LOW       4'h3
`define TSR_IDX_COEF_HIGH      4'h4
`define TSR_IDX_ACT_SUBSTATE   4'h5
`define TSR_IDX_GAIN_STATE     4'h6
`define TSR_IDX_COEF_SELECT    4'h8
// ----------------------------------------
// Field positions of gain_and_activation_state
// ----------------------------------------
`define TSR_ST_HIGH_BIT        7
`define TSR_ST_MID_BIT         6
`define TSR_DGAIN_MSB          5
`define TSR_DGAIN_LSB          4
`define TSR_ST_LOW_BIT         3
`define TSR_AGAIN_MSB          2
`define TSR_AGAIN_LSB          0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define TSR_RST_BYTE           8'h00
`define TSR_RST_WORD           16'h0000
`define TSR_SUB_IDLE           4'h0
`define TSR_MODE_FRAMED_A      3'h6
`define TSR_MODE_FRAMED_B      3'h7
`define TSR_SYNC_STAGES        2
`endif

// File: tsr_pkg.sv
// Types shared by the status readout block
package tsr_pkg;
   // ----------------------------------------
   // Top-level activation state codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      TSR_INACTIVE    = 3'h0,
      TSR_ACTIVATING  = 3'h1,
      TSR_ACTIVE_TMR  = 3'h2,
      TSR_ACTIVE_FRM  = 3'h3,
      TSR_PEND_DEACT  = 3'h4,
      TSR_DEACTIVATED = 3'h5,
      TSR_UNUSED      = 3'h6,
      TSR_TIMEOUT_ACT = 3'h7
   } tsr_act_state_type;

   // ----------------------------------------
   // Activating phases reported by the training sequencer
   // ----------------------------------------
   typedef enum logic [3:0] {
      TSR_PH_WAIT          = 4'h0,
      TSR_PH_PRE_GAIN      = 4'h1,
      TSR_PH_PRE_ECHO      = 4'h2,
      TSR_PH_SIGNAL_DETECT = 4'h3,
      TSR_PH_ANALOG_GAIN   = 4'h4,
      TSR_PH_ECHO_CANCEL   = 4'h5,
      TSR_PH_PHASE_LOCK1   = 4'h6,
      TSR_PH_PHASE_LOCK2   = 4'h7,
      TSR_PH_FOUR_LEVEL    = 4'h8,
      TSR_PH_FRAME_DETECT  = 4'h9
   } tsr_phase_type;

   // ----------------------------------------
   // Status sources from the data pump core
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]        noise_margin;
      tsr_act_state_type act_state;
      tsr_phase_type     phase;
      logic              master_role;
      logic [2:0]        op_mode;
      logic [1:0]        digital_gain_code;
      logic [2:0]        analog_gain_code;
      logic              micro_interrupt;
      logic              rx_data;
   } tsr_status_type;

   // ----------------------------------------
   // Whole state of the readout block
   // ----------------------------------------
   typedef struct packed {
      logic [7:0]  noise_margin;
      logic [15:0] coef_word;
      logic [3:0]  substate;
      logic [7:0]  gain_state;
      logic [7:0]  coef_select;
      logic [1:0]  strobe_sync;
      logic        strobe_prev;
      logic        rxd;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tsr_state_type;
endpackage : tsr_pkg

// File: tsr_status_readout.sv
// APB status readout register bank of the line transceiver
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "tsr_defs.svh"

// Overview of operation
// - Noise margin reads as signed 8-bit code, half dB per step.
// - Host writes coefficient index first; device then shows that coefficient.
// - Coefficient bits 7:0 read at low byte, bits 15:8 at high byte.
// - Coefficient word refreshed on every rising frame strobe edge.
// - Low coefficient byte at index 3, high byte at index 4.
// - Status registers are read-only; contents meaningless until first update.
// - Substate code reads 0000 outside the Activating state.
// - Master substate codes 0001 to 1000, pre-gain through frame detect.
// - Slave substate codes 0001 to 0111, wait through frame detect.
// - Frame detect phase only in operating modes 6 and 7, skipped otherwise.
// - State indicator bits sit at B7, B6, B3, most significant first.
// - Digital gain code at B5:B4, gain of two to the code.
// - Analog gain code at B2:B0, -12 dB to +2 dB in 2 dB steps.
// - State codes 000 to 101 as the activation state list gives.
// - Code 111 is micro-interruption time-out or transparent/independent Active.
// - Receive data driven only while Active, held high otherwise.
module tsr_status_readout
   import tsr_pkg::*;
(
   input  wire logic           clk_in,
   input  wire logic           nrst_in,
   input  wire logic           psel_in,
   input  wire logic           penable_in,
   input  wire logic           pwrite_in,
   input  wire logic [11:0]    paddr_in,
   input  wire logic [31:0]    pwdata_in,
   output logic      [31:0]    prdata_out,
   output logic                pready_out,
   output logic                pslverr_out,
   input  wire tsr_status_type status_in,
   input  wire logic [15:0]    coef_value_in,
   input  wire logic           frame_strobe_in,
   output logic      [7:0]     coef_select_out,
   output logic                rxd_out
);

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   function automatic logic is_framed(input logic [2:0] mode);
      is_framed = (mode == `TSR_MODE_FRAMED_A) || (mode == `TSR_MODE_FRAMED_B);
   endfunction : is_framed

   // Active covers both Active codes and code 111 outside a micro-interruption
   function automatic logic is_active(input tsr_status_type s);
      is_active = (s.act_state == TSR_ACTIVE_TMR) || (s.act_state == TSR_ACTIVE_FRM) ||
                  ((s.act_state == TSR_TIMEOUT_ACT) && !s.micro_interrupt);
   endfunction : is_active

   // Phase to reported code; a phase the role does not have reports idle
   function automatic logic [3:0] phase_code(input tsr_phase_type ph, input logic master);
      logic [3:0] c;
      c = `TSR_SUB_IDLE;
      if (master) begin
         unique case (ph)
            TSR_PH_PRE_GAIN:      c = 4'h1;
            TSR_PH_PRE_ECHO:      c = 4'h2;
            TSR_PH_SIGNAL_DETECT: c = 4'h3;
            TSR_PH_ANALOG_GAIN:   c = 4'h4;
            TSR_PH_ECHO_CANCEL:   c = 4'h5;
            TSR_PH_PHASE_LOCK1:   c = 4'h6;
            TSR_PH_FOUR_LEVEL:    c = 4'h7;
            TSR_PH_FRAME_DETECT:  c = 4'h8;
            default:              c = `TSR_SUB_IDLE;
         endcase
      end else begin
         unique case (ph)
            TSR_PH_WAIT:          c = 4'h1;
            TSR_PH_ANALOG_GAIN:   c = 4'h2;
            TSR_PH_ECHO_CANCEL:   c = 4'h3;
            TSR_PH_PHASE_LOCK1:   c = 4'h4;
            TSR_PH_PHASE_LOCK2:   c = 4'h5;
            TSR_PH_FOUR_LEVEL:    c = 4'h6;
            TSR_PH_FRAME_DETECT:  c = 4'h7;
            default:              c = `TSR_SUB_IDLE;
         endcase
      end
      phase_code = c;
   endfunction : phase_code

   function automatic logic [3:0] reg_index(input logic [11:0] addr);
      reg_index = addr[5:2];
   endfunction : reg_index

   // ----------------------------------------
   // State
   // ----------------------------------------
   tsr_state_type st_q;
   tsr_state_type st_d;
   logic          strobe_rise;
   logic          access;
   logic          mapped;
   logic          writable;
   logic [7:0]    rd_byte;
   logic [3:0]    idx;

   assign strobe_rise = st_q.strobe_sync[1] && !st_q.strobe_prev;
   assign idx         = reg_index(paddr_in);
   assign access      = psel_in && penable_in;

   // ----------------------------------------
   // Register read decode
   // ----------------------------------------
   always_comb begin
      rd_byte  = `TSR_RST_BYTE;
      mapped   = 1'b1;
      writable = 1'b0;
      if (paddr_in[1:0] != 2'b00 || paddr_in[11:6] != 6'h00) begin
         mapped = 1'b0;
      end else begin
         unique case (idx)
            `TSR_IDX_NOISE_MARGIN: rd_byte = st_q.noise_margin;
            `TSR_IDX_COEF_LOW:     rd_byte = st_q.coef_word[7:0];
            `TSR_IDX_COEF_HIGH:    rd_byte = st_q.coef_word[15:8];
            `TSR_IDX_ACT_SUBSTATE: rd_byte = {4'h0, st_q.substate};
            `TSR_IDX_GAIN_STATE:   rd_byte = st_q.gain_state;
            `TSR_IDX_COEF_SELECT: begin
               rd_byte  = st_q.coef_select;
               writable = 1'b1;
            end
            default:               mapped = 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      // Pin strobe crosses in through two flops before the edge detector
      st_d.strobe_sync = {st_q.strobe_sync[0], frame_strobe_in};
      st_d.strobe_prev = st_q.strobe_sync[1];

      // Margin code is passed through unchanged, so scaling stays with the core
      st_d.noise_margin = status_in.noise_margin;

      // The core maps coef_select to coef_value_in; latched only on a strobe
      if (strobe_rise) begin
         st_d.coef_word = coef_value_in;
      end

      if (status_in.act_state != TSR_ACTIVATING) begin
         st_d.substate = `TSR_SUB_IDLE;
      end else if (status_in.phase == TSR_PH_FRAME_DETECT && !is_framed(status_in.op_mode)) begin
         st_d.substate = st_q.substate;
      end else begin
         st_d.substate = phase_code(status_in.phase, status_in.master_role);
      end

      st_d.gain_state[`TSR_ST_HIGH_BIT] = status_in.act_state[2];
      st_d.gain_state[`TSR_ST_MID_BIT]  = status_in.act_state[1];
      st_d.gain_state[`TSR_ST_LOW_BIT]  = status_in.act_state[0];
      st_d.gain_state[`TSR_DGAIN_MSB:`TSR_DGAIN_LSB] = status_in.digital_gain_code;
      st_d.gain_state[`TSR_AGAIN_MSB:`TSR_AGAIN_LSB] = status_in.analog_gain_code;

      st_d.rxd = is_active(status_in) ? status_in.rx_data : 1'b1;

      // Two-cycle access: pready rises in the second access cycle
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      if (access && !st_q.pready) begin
         st_d.pready  = 1'b1;
         st_d.pslverr = !mapped || (pwrite_in && !writable);
         st_d.prdata  = pwrite_in ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
      // Write lands only at the edge where the master sees pready
      if (access && st_q.pready && pwrite_in && mapped && writable) begin
         st_d.coef_select = pwdata_in[7:0];
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q.noise_margin <= `TSR_RST_BYTE;
         st_q.coef_word    <= `TSR_RST_WORD;
         st_q.substate     <= `TSR_SUB_IDLE;
         st_q.gain_state   <= `TSR_RST_BYTE;
         st_q.coef_select  <= `TSR_RST_BYTE;
         st_q.strobe_sync  <= 2'b00;
         st_q.strobe_prev  <= 1'b0;
         st_q.rxd          <= 1'b1;
         st_q.pready       <= 1'b0;
         st_q.pslverr      <= 1'b0;
         st_q.prdata       <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_out      = st_q.prdata;
   assign pready_out      = st_q.pready;
   assign pslverr_out     = st_q.pslverr;
   assign coef_select_out = st_q.coef_select;
   assign rxd_out         = st_q.rxd;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Byte views for the coefficient read checks and the select write check
   logic [7:0]    coef_lo_w;
   logic [7:0]    coef_hi_w;
   logic [7:0]    wdata_lo_w;

   assign coef_lo_w  = st_q.coef_word[7:0];
   assign coef_hi_w  = st_q.coef_word[15:8];
   assign wdata_lo_w = pwdata_in[7:0];

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   AST_MARGIN_PASS: assert property (
      ##1 st_q.noise_margin == $past(status_in.noise_margin))
      else $error("noise margin not passed through");

   AST_COEF_REFRESH: assert property (
      $rose(st_q.strobe_sync[1]) |=> st_q.coef_word == $past(coef_value_in))
      else $error("coefficient word not refreshed on strobe");

   AST_COEF_HOLD: assert property (
      !(st_q.strobe_sync[1] && !st_q.strobe_prev) |=> $stable(st_q.coef_word))
      else $error("coefficient word changed without strobe");

   AST_COEF_BYTES: assert property (
      access && !pready_out && !pwrite_in && paddr_in == 12'h00c
      |=> prdata_out[7:0] == $past(coef_lo_w) && pready_out)
      else $error("low coefficient byte misread");

   AST_COEF_HIGH: assert property (
      access && !pready_out && !pwrite_in && paddr_in == 12'h010
      |=> prdata_out == {24'h00_0000, $past(coef_hi_w)})
      else $error("high coefficient byte misread");

   AST_IDLE_SUB: assert property (
      status_in.act_state != TSR_ACTIVATING |=> st_q.substate == 4'h0)
      else $error("substate not idle outside activating");

   AST_MASTER_FRM: assert property (
      status_in.act_state == TSR_ACTIVATING && status_in.master_role &&
      status_in.phase == TSR_PH_FRAME_DETECT && status_in.op_mode == 3'h6
      |=> st_q.substate == 4'h8)
      else $error("master frame detect code wrong");

   AST_SLAVE_WAIT: assert property (
      status_in.act_state == TSR_ACTIVATING && !status_in.master_role &&
      status_in.phase == TSR_PH_WAIT |=> st_q.substate == 4'h1)
      else $error("slave wait code wrong");

   AST_FRM_SKIP: assert property (
      status_in.act_state == TSR_ACTIVATING &&
      status_in.phase == TSR_PH_FRAME_DETECT && status_in.op_mode < 3'h6 |=> $stable(st_q.substate))
      else $error("frame detect reported in unframed mode");

   AST_STATE_BITS: assert property (
      ##1 {st_q.gain_state[7:6], st_q.gain_state[3]} == $past(status_in.act_state))
      else $error("state indicator bits misplaced");

   AST_GAIN_BITS: assert property (
      ##1 st_q.gain_state[5:4] == $past(status_in.digital_gain_code) &&
          st_q.gain_state[2:0] == $past(status_in.analog_gain_code))
      else $error("gain codes misplaced");

   AST_RXD_IDLE: assert property (
      status_in.act_state inside {TSR_INACTIVE, TSR_ACTIVATING, TSR_PEND_DEACT, TSR_DEACTIVATED}
      |=> rxd_out)
      else $error("receive data not held high");

   AST_RO_WRITE: assert property (
      access && !pready_out && pwrite_in && paddr_in inside {12'h008, 12'h00c, 12'h010, 12'h014, 12'h018}
      |=> pslverr_out && pready_out ##1 $stable(coef_select_out))
      else $error("write to read-only register accepted");

   AST_SELECT_WRITE: assert property (
      access && pready_out && pwrite_in && paddr_in == 12'h020 |=> coef_select_out == $past(wdata_lo_w))
      else $error("coefficient select not written");

   AST_MARGIN_READ: assert property (
      access && !pready_out && !pwrite_in && paddr_in == 12'h008
      |=> prdata_out == {24'h00_0000, $past(st_q.noise_margin)})
      else $error("noise margin misread");

   AST_SUB_READ: assert property (
      access && !pready_out && !pwrite_in && paddr_in == 12'h014
      |=> prdata_out == {28'h000_0000, $past(st_q.substate)})
      else $error("substate misread");

   AST_GS_READ: assert property (
      access && !pready_out && !pwrite_in && paddr_in == 12'h018
      |=> prdata_out == {24'h00_0000, $past(st_q.gain_state)})
      else $error("gain and state byte misread");

   AST_UPPER_ZERO: assert property (
      pready_out |-> prdata_out[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");

   AST_UNMAPPED: assert property (
      access && !pready_out && paddr_in == 12'h03c |=> pready_out && pslverr_out)
      else $error("unmapped address not refused");

   AST_READ_KEEPS: assert property (
      access && !pwrite_in |=> $stable(coef_select_out))
      else $error("read altered coefficient select");

   AST_MASTER_PREGAIN: assert property (
      status_in.act_state == TSR_ACTIVATING && status_in.master_role &&
      status_in.phase == TSR_PH_PRE_GAIN |=> st_q.substate == 4'h1)
      else $error("master pre-gain code wrong");

   AST_MASTER_FOUR: assert property (
      status_in.act_state == TSR_ACTIVATING && status_in.master_role &&
      status_in.phase == TSR_PH_FOUR_LEVEL |=> st_q.substate == 4'h7)
      else $error("master four-level code wrong");

   AST_SLAVE_FRM: assert property (
      status_in.act_state == TSR_ACTIVATING && !status_in.master_role &&
      status_in.phase == TSR_PH_FRAME_DETECT && status_in.op_mode == 3'h7
      |=> st_q.substate == 4'h7)
      else $error("slave frame detect code wrong");

   AST_SLAVE_FOUR: assert property (
      status_in.act_state == TSR_ACTIVATING && !status_in.master_role &&
      status_in.phase == TSR_PH_FOUR_LEVEL |=> st_q.substate == 4'h6)
      else $error("slave four-level code wrong");

   AST_MASTER_SKIP: assert property (
      status_in.act_state == TSR_ACTIVATING && status_in.master_role &&
      status_in.phase == TSR_PH_FRAME_DETECT && status_in.op_mode < 3'h6
      |=> st_q.substate != 4'h8)
      else $error("master frame detect reported in unframed mode");

   AST_STATE_FRAMED: assert property (
      status_in.act_state == TSR_ACTIVE_FRM |=> st_q.gain_state[7:6] == 2'b01 && st_q.gain_state[3])
      else $error("framed active code wrong");

   AST_STATE_TIMEOUT: assert property (
      status_in.act_state == TSR_TIMEOUT_ACT |=> st_q.gain_state[7:6] == 2'b11 && st_q.gain_state[3])
      else $error("time-out or plain active code wrong");

   AST_DIGITAL_TOP: assert property (
      status_in.digital_gain_code == 2'h3 |=> st_q.gain_state[5:4] == 2'b11)
      else $error("top digital gain code wrong");

   AST_ANALOG_TOP: assert property (
      status_in.analog_gain_code == 3'h7 |=> st_q.gain_state[2:0] == 3'h7)
      else $error("top analog gain code wrong");

   AST_RXD_PASS: assert property (
      status_in.act_state inside {TSR_ACTIVE_TMR, TSR_ACTIVE_FRM} |=> rxd_out == $past(status_in.rx_data))
      else $error("receive data not passed while active");

   AST_RXD_TIMEOUT: assert property (
      status_in.act_state == TSR_TIMEOUT_ACT && status_in.micro_interrupt |=> rxd_out)
      else $error("receive data not held high in time-out");

   COV_STROBE:  cover property ($rose(st_q.strobe_sync[1]) ##2 access);
   COV_MASTER:  cover property (st_q.substate == 4'h8);
   COV_SLAVE:   cover property (st_q.substate == 4'h7);
   COV_ACTIVE:  cover property (status_in.act_state == TSR_ACTIVE_FRM ##1 !rxd_out);
   COV_SKIP:    cover property (status_in.act_state == TSR_ACTIVATING && status_in.phase == TSR_PH_FRAME_DETECT &&
                                status_in.op_mode == 3'h0);

endmodule : tsr_status_readout

// File: tsr_core_model.sv
// Data pump core model that answers coefficient lookups
`timescale 1ns/1ps
module tsr_core_model (
   input  wire logic [7:0]  coef_select_in,
   output logic      [15:0] coef_value_out
);
   // Distinct upper and lower bytes, so a byte swap cannot pass unseen
   assign coef_value_out = {coef_select_in ^ 8'ha5, coef_select_in};
endmodule : tsr_core_model

// File: tb.sv
// Self-checking testbench of the status readout register bank
`timescale 1ns/1ps
`include "tsr_defs.svh"
module tb;
   import tsr_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam logic [11:0] A_NM  = {6'h00, `TSR_IDX_NOISE_MARGIN, 2'b00};
   localparam logic [11:0] A_LO  = {6'h00, `TSR_IDX_COEF_LOW, 2'b00};
   localparam logic [11:0] A_HI  = {6'h00, `TSR_IDX_COEF_HIGH, 2'b00};
   localparam logic [11:0] A_SUB = {6'h00, `TSR_IDX_ACT_SUBSTATE, 2'b00};
   localparam logic [11:0] A_GS  = {6'h00, `TSR_IDX_GAIN_STATE, 2'b00};
   localparam logic [11:0] A_SEL = {6'h00, `TSR_IDX_COEF_SELECT, 2'b00};
   logic           clk_in = 1'b0;
   logic           nrst_in = 1'b0;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [11:0]    paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata_out;
   logic           pready_out;
   logic           pslverr_out;
   tsr_status_type st = '0;
   logic [15:0]    coef_value;
   logic           fs = 1'b0;
   logic [7:0]     coef_select_out;
   logic           rxd_out;
   int             n_fail = 0;
   int             checks = 0;
   always #50 clk_in = ~clk_in;
   tsr_status_readout dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .status_in(st), .coef_value_in(coef_value),
      .frame_strobe_in(fs), .coef_select_out(coef_select_out), .rxd_out(rxd_out));
   tsr_core_model core_u (.coef_select_in(coef_select_out), .coef_value_out(coef_value));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic close_out;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Request holds until pready is seen at a rising edge; data and error are taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1 && n < 20) begin
         @(posedge clk_in);
         n++;
      end
      if (pready_out !== 1'b1) begin
         n_fail++;
         $display("BAD t=%0t pready=%h exp=%h", $time, pready_out, 1'b1);
      end
      r = prdata_out;
      e = pslverr_out;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk({31'h0, e}, {31'h0, exp_err});
      if (!exp_err) chk(r, exp);
   endtask : rd
   task automatic settle;
      repeat (2) @(posedge clk_in);
   endtask : settle
   task automatic strobe;
      @(posedge clk_in);
      fs <= 1'b1;
      repeat (3) @(posedge clk_in);
      fs <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask : strobe
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_coef;
      logic [31:0] r;
      logic        e;
      apb(1'b1, A_SEL, 32'h0000_005a, r, e);
      chk({31'h0, e}, 32'h0);
      @(posedge clk_in);
      chk({24'h0, coef_select_out}, 32'h5a);
      rd(A_SEL, 32'h5a, 1'b0);
      strobe();
      rd(A_LO, 32'h5a, 1'b0);
      rd(A_HI, 32'h5a ^ 32'ha5, 1'b0);
      apb(1'b1, A_SEL, 32'h0000_0033, r, e);
      rd(A_HI, 32'h5a ^ 32'ha5, 1'b0);
      strobe();
      rd(A_LO, 32'h33, 1'b0);
      rd(A_HI, 32'h33 ^ 32'ha5, 1'b0);
   endtask : t_coef
   task automatic t_margin;
      logic [31:0] r;
      logic        e;
      @(posedge clk_in);
      st.noise_margin <= 8'h1a;
      settle();
      rd(A_NM, 32'h1a, 1'b0);
      // Host correction after a 6 dB receiver gain step: 12 half-dB codes off
      apb(1'b0, A_NM, 32'h0, r, e);
      chk(r - 32'd12, 32'h0000_000e);
      st.noise_margin <= 8'hf4;
      settle();
      rd(A_NM, 32'hf4, 1'b0);
      rd(A_NM, 32'hf4, 1'b0);
      apb(1'b1, A_NM, 32'h0000_0011, r, e);
      chk({31'h0, e}, 32'h1);
      rd(A_NM, 32'hf4, 1'b0);
      rd(12'h03c, 32'h0, 1'b1);
   endtask : t_margin
   task automatic t_gain_state;
      logic [2:0] s;
      for (int i = 0; i < 8; i++) begin
         if (i == 6) continue;
         s = i[2:0];
         @(posedge clk_in);
         st.act_state <= tsr_act_state_type'(s);
         st.digital_gain_code <= i[1:0];
         st.analog_gain_code <= s ^ 3'h5;
         st.micro_interrupt <= 1'b0;
         st.rx_data <= 1'b0;
         settle();
         rd(A_GS, {24'h0, s[2], s[1], i[1:0], s[0], s ^ 3'h5}, 1'b0);
         chk({31'h0, rxd_out}, {31'h0, !(s == 3'h2 || s == 3'h3 || s == 3'h7)});
      end
      st.micro_interrupt <= 1'b1;
      settle();
      chk({31'h0, rxd_out}, 32'h1);
   endtask : t_gain_state
   task automatic t_substate;
      tsr_phase_type ph_m[8] = '{TSR_PH_PRE_GAIN, TSR_PH_PRE_ECHO, TSR_PH_SIGNAL_DETECT, TSR_PH_ANALOG_GAIN,
                                 TSR_PH_ECHO_CANCEL, TSR_PH_PHASE_LOCK1, TSR_PH_FOUR_LEVEL, TSR_PH_FRAME_DETECT};
      tsr_phase_type ph_s[7] = '{TSR_PH_WAIT, TSR_PH_ANALOG_GAIN, TSR_PH_ECHO_CANCEL, TSR_PH_PHASE_LOCK1,
                                 TSR_PH_PHASE_LOCK2, TSR_PH_FOUR_LEVEL, TSR_PH_FRAME_DETECT};
      @(posedge clk_in);
      st.act_state <= TSR_ACTIVATING;
      st.op_mode <= `TSR_MODE_FRAMED_A;
      st.master_role <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         st.phase <= ph_m[i];
         settle();
         rd(A_SUB, i + 1, 1'b0);
      end
      st.master_role <= 1'b0;
      st.op_mode <= `TSR_MODE_FRAMED_B;
      for (int i = 0; i < 7; i++) begin
         st.phase <= ph_s[i];
         settle();
         rd(A_SUB, i + 1, 1'b0);
      end
      st.phase <= TSR_PH_PRE_GAIN;
      settle();
      rd(A_SUB, 32'h0, 1'b0);
      st.op_mode <= 3'h0;
      st.phase <= TSR_PH_FOUR_LEVEL;
      settle();
      st.phase <= TSR_PH_FRAME_DETECT;
      settle();
      rd(A_SUB, 32'h6, 1'b0);
      st.master_role <= 1'b1;
      st.phase <= TSR_PH_FOUR_LEVEL;
      settle();
      st.phase <= TSR_PH_FRAME_DETECT;
      settle();
      rd(A_SUB, 32'h7, 1'b0);
      st.act_state <= TSR_ACTIVE_FRM;
      settle();
      rd(A_SUB, 32'h0, 1'b0);
   endtask : t_substate
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_coef();
      t_margin();
      t_gain_state();
      t_substate();
      close_out();
   end
   initial begin
      #2000000;
      n_fail++;
      close_out();
   end
endmodule : tb
